// >>> core/tstf_defs.vh
// Overview of operation
// - A 32-bit master count advances once per master clock cycle.
// - A 32-bit GPS seconds count increments once per second, zero at epoch.
// - One second after epoch the master count reads 10240000.
// - Initial count is 1024 times 10000 times (seconds mod 262144), mod 2^32.
// - The master count loads from the mapping on a seconds write, and on a second boundary only in GPS mode or when realigning.
// - Every time-of-day mode converts its time to equivalent GPS seconds.
// - A control selects user, default, network or GPS time-of-day mode.
// - Network mode accepts protocol version 3 or later only.
// - Free-run or network to GPS always passes through GPS frequency mode.
// - GPS frequency mode steers frequency while counters keep counting.
// - Leaving GPS frequency mode for GPS realigns counters, possibly a step.
// - A user-scheduled time moves GPS frequency mode into GPS mode.
// - GPS frequency mode keeps setting mode and validity unless user changes.
// - Frequency slew can remove at least 1 ms offset within 24 hours.
// - Suspended network-mode frequency adjustment raises a status flag.
// - After warm-up a degrading change to network mode may be refused.
// - User and default modes need no adjustment after the initial setting.
// - Frame is preamble, payload, 16-bit CRC, 234 bits; CRC over payload.
// - Frame clock rising edge aligns with the first preamble bit.
// - Within each field the most significant bit goes on the line first.
// - The nine fields go out in ascending field-number order.
// - Timeslot is 1024 master clocks; bit period two clocks, 512 per slot.
// - Frame carries the 22 upper count bits; client counts the low 10.
// - Line data is Manchester at 5.12 Mbps locked to the master clock.
`ifndef TSTF_DEFS_VH
`define TSTF_DEFS_VH
`define TSTF_CLK_NS         50
`define TSTF_SLOT_CLKS      11'h400
`define TSTF_TICKS_PER_SEC  32'h009C4000
`define TSTF_SEC_MOD_BITS   18
`define TSTF_SLOTS_PER_SEC  14'h2710
`define TSTF_FRAME_BITS     9'h0EA
`define TSTF_PREAMBLE_BITS  9'h044
`define TSTF_CRC_BITS       9'h010
`define TSTF_HALF_SLOT_BIT  9'h100
`define TSTF_NTP_MIN_VER    3'h3
`define TSTF_MODE_USER      3'h0
`define TSTF_MODE_DEFAULT   3'h1
`define TSTF_MODE_NTP       3'h2
`define TSTF_MODE_GPSFREQ   3'h3
`define TSTF_MODE_GPS       3'h4
`define TSTF_MODE_FREERUN   3'h5
`define TSTF_CRC_POLY       16'h1021
`define TSTF_CRC_INIT       16'hFFFF
`define TSTF_REG_CTRL       4'h0
`define TSTF_REG_SETSEC     4'h1
`define TSTF_REG_SCHED      4'h2
`define TSTF_REG_STATUS     4'h3
`define TSTF_REG_COUNT      4'h4
`define TSTF_REG_GPSSEC     4'h5
`define TSTF_REG_STEER      4'h6
`define TSTF_REG_PAYLOAD    4'h7
`define TSTF_REG_NTPVER     4'h8
`endif

// >>> core/tstf_sync2.v
`timescale 1ns/100ps
`default_nettype none
module tstf_sync2 #(
    parameter W = 1
) (
    input  wire         clk_sys,
    input  wire         nrst,
    input  wire [W-1:0] d,
    output wire [W-1:0] q
);
    reg [W-1:0] s1_r;
    reg [W-1:0] s2_r;
    always @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            s1_r <= {W{1'b0}};
            s2_r <= {W{1'b0}};
        end else begin
            s1_r <= d;
            s2_r <= s1_r;
        end
    end
    assign q = s2_r;
endmodule
`default_nettype wire

// >>> core/tstf_map.v
`timescale 1ns/100ps
`default_nettype none
`include "tstf_defs.vh"
// Seconds to master count; pure logic, multiplier kept narrow by shifts.
module tstf_map (
    input  wire [31:0] gps_sec,
    output wire [31:0] count
);
    wire [17:0] sec_mod;
    wire [31:0] prod;
    assign sec_mod = gps_sec[`TSTF_SEC_MOD_BITS-1:0];
    // 10000 * 1024 fits in 24 bits; the product keeps its low 32 bits
    assign prod = {14'h0000, sec_mod} * {18'h00000, `TSTF_SLOTS_PER_SEC};
    assign count = {prod[21:0], 10'h000};
endmodule
`default_nettype wire

// >>> core/tstf_top.v
// Strobed register access and the register addresses are this design's own decisions.
`timescale 1ns/100ps
`default_nettype none
`include "tstf_defs.vh"
module tstf_top #(
    parameter [31:0] TICKS_PER_SEC = `TSTF_TICKS_PER_SEC
) (
    input  wire        clk_sys,
    input  wire        nrst,
    input  wire [3:0]  reg_addr,
    input  wire [31:0] reg_wdata,
    input  wire        reg_wr,
    input  wire        reg_rd,
    output reg  [31:0] reg_rdata,
    input  wire        gps_pps,
    input  wire        warmup_done,
    output reg         line_out,
    output reg         line_oe,
    output reg         frame_clk,
    output reg         freq_up,
    output reg         freq_dn,
    output wire [31:0] master_time_count
);
    reg  [31:0] count_r;
    reg  [31:0] gps_sec_r;
    reg  [31:0] tick_r;
    reg  [2:0]  mode_r;
    reg  [2:0]  req_mode_r;
    reg         tod_valid_r;
    reg         refused_r;
    reg         ntp_susp_r;
    reg         realign_r;
    reg  [31:0] set_sec_r;
    reg  [31:0] sched_r;
    reg  [2:0]  ntp_ver_r;
    reg  [15:0] steer_r;
    reg  [15:0] steer_acc_r;
    reg  [77:0] payload_r;
    reg  [233:0] shift_r;
    reg  [8:0]  bit_idx_r;
    reg  [15:0] crc_r;
    reg         pps_d_r;
    wire        pps_s;
    wire        warm_s;
    wire [31:0] map_now;
    wire [31:0] map_next;
    wire        pps_edge;
    wire        sec_tick;
    wire        slot_start;
    wire [8:0]  bit_cnt;
    wire        crc_fb;
    wire [15:0] crc_nxt;
    wire        in_payload;

    tstf_sync2 #(.W(2)) u_sync (
        .clk_sys (clk_sys),
        .nrst    (nrst),
        .d       ({gps_pps, warmup_done}),
        .q       ({pps_s, warm_s})
    );
    // Maps the seconds value being written, so the load lands on that second
    tstf_map u_map_now (
        .gps_sec (reg_wdata),
        .count   (map_now)
    );
    tstf_map u_map_next (
        .gps_sec (gps_sec_r + 32'h00000001),
        .count   (map_next)
    );

    assign master_time_count = count_r;
    assign pps_edge   = pps_s & ~pps_d_r;
    // Second boundary: GPS pulse in GPS mode, own tick elsewhere
    assign sec_tick   = (mode_r == `TSTF_MODE_GPS) ? pps_edge :
                        (tick_r == TICKS_PER_SEC - 32'h00000001);
    assign bit_cnt    = count_r[9:1];
    assign slot_start = (count_r[9:0] == 10'h000);
    assign in_payload = (bit_idx_r >= `TSTF_PREAMBLE_BITS) &&
                        (bit_idx_r < `TSTF_FRAME_BITS - `TSTF_CRC_BITS);
    assign crc_fb     = shift_r[233] ^ crc_r[15];
    assign crc_nxt    = {crc_r[14:0], 1'b0} ^
                        (crc_fb ? `TSTF_CRC_POLY : 16'h0000);

    // Timebase
    always @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            count_r     <= 32'h00000000;
            gps_sec_r   <= 32'h00000000;
            tick_r      <= 32'h00000000;
            pps_d_r     <= 1'b0;
            realign_r   <= 1'b0;
            steer_acc_r <= 16'h0000;
            freq_up     <= 1'b0;
            freq_dn     <= 1'b0;
        end else begin
            pps_d_r <= pps_s;
            // Unsigned accumulator of steering bits 14:0 pulses freq_up on carry; bit 15 drives freq_dn directly
            {freq_up, steer_acc_r} <= {1'b0, steer_acc_r} +
                                      {1'b0, steer_r[14:0], 1'b0};
            freq_dn <= steer_r[15];
            // A seconds load starts a fresh second
            if (sec_tick || (reg_wr && reg_addr == `TSTF_REG_SETSEC))
                tick_r <= 32'h00000000;
            else
                tick_r <= tick_r + 32'h00000001;
            if (reg_wr && reg_addr == `TSTF_REG_SETSEC) begin
                gps_sec_r <= reg_wdata;
                count_r   <= map_now;
            end else if (sec_tick) begin
                gps_sec_r <= gps_sec_r + 32'h00000001;
                if (realign_r || mode_r == `TSTF_MODE_GPS) begin
                    count_r   <= map_next;
                    realign_r <= 1'b0;
                end else begin
                    count_r <= count_r + 32'h00000001;
                end
            end else begin
                // Free count wraps naturally; no flag or reload on wrap
                count_r <= count_r + 32'h00000001;
            end
            if (mode_r == `TSTF_MODE_GPSFREQ && gps_sec_r >= sched_r &&
                req_mode_r == `TSTF_MODE_GPS && !(realign_r && sec_tick))
                realign_r <= 1'b1;
        end
    end

    // Mode control
    always @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            mode_r      <= `TSTF_MODE_DEFAULT;
            req_mode_r  <= `TSTF_MODE_DEFAULT;
            tod_valid_r <= 1'b0;
            refused_r   <= 1'b0;
            ntp_susp_r  <= 1'b0;
            set_sec_r   <= 32'h00000000;
            sched_r     <= 32'hFFFFFFFF;
            ntp_ver_r   <= `TSTF_NTP_MIN_VER;
            steer_r     <= 16'h0000;
        end else begin
            if (reg_wr) begin
                case (reg_addr)
                `TSTF_REG_CTRL: begin
                    req_mode_r <= reg_wdata[2:0];
                    ntp_susp_r <= reg_wdata[8];
                    if (reg_wdata[2:0] == `TSTF_MODE_GPS &&
                        (mode_r == `TSTF_MODE_FREERUN ||
                         mode_r == `TSTF_MODE_NTP ||
                         mode_r == `TSTF_MODE_USER ||
                         mode_r == `TSTF_MODE_DEFAULT))
                        mode_r <= `TSTF_MODE_GPSFREQ;
                    else if (reg_wdata[2:0] == `TSTF_MODE_NTP &&
                             (ntp_ver_r < `TSTF_NTP_MIN_VER ||
                              (warm_s && reg_wdata[9])))
                        refused_r <= 1'b1;
                    else if (reg_wdata[2:0] == `TSTF_MODE_GPSFREQ ||
                             reg_wdata[2:0] == `TSTF_MODE_GPS)
                        mode_r <= mode_r;
                    else begin
                        mode_r    <= reg_wdata[2:0];
                        refused_r <= 1'b0;
                    end
                end
                `TSTF_REG_SETSEC: begin
                    set_sec_r   <= reg_wdata;
                    tod_valid_r <= 1'b1;
                end
                `TSTF_REG_SCHED:  sched_r   <= reg_wdata;
                `TSTF_REG_STEER:  steer_r   <= reg_wdata[15:0];
                `TSTF_REG_NTPVER: ntp_ver_r <= reg_wdata[2:0];
                default: ;
                endcase
            end else if (realign_r && sec_tick) begin
                mode_r      <= `TSTF_MODE_GPS;
                tod_valid_r <= 1'b1;
            end
        end
    end

    // Framer: frame starts at bit slot 0 of each timeslot
    always @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            payload_r <= {78{1'b1}};
            shift_r   <= {234{1'b0}};
            bit_idx_r <= `TSTF_FRAME_BITS;
            crc_r     <= `TSTF_CRC_INIT;
            line_out  <= 1'b0;
            line_oe   <= 1'b0;
            frame_clk <= 1'b0;
        end else begin
            if (reg_wr && reg_addr == `TSTF_REG_PAYLOAD)
                payload_r <= {payload_r[45:0], reg_wdata};
            frame_clk <= (bit_cnt < `TSTF_HALF_SLOT_BIT);
            if (slot_start) begin
                // Fields 1..8 concatenated in ascending order, MSB first
                shift_r <= {64'hAAAAAAAAAAAAAAAA, 4'h9,
                            payload_r[77:62], count_r[31:10],
                            payload_r[61:0], {50{1'b1}},
                            16'h0000};
                bit_idx_r <= 9'h000;
                crc_r     <= `TSTF_CRC_INIT;
            end else if (count_r[0] && bit_idx_r < `TSTF_FRAME_BITS) begin
                bit_idx_r <= bit_idx_r + 9'h001;
                if (in_payload) begin
                    crc_r   <= crc_nxt;
                    shift_r <= {shift_r[232:0], 1'b0};
                    if (bit_idx_r == `TSTF_FRAME_BITS - `TSTF_CRC_BITS
                                     - 9'h001)
                        shift_r[233:218] <= crc_nxt;
                end else begin
                    shift_r <= {shift_r[232:0], 1'b0};
                end
            end
            // Manchester: data in first half bit, inverse in second
            line_oe  <= (bit_idx_r < `TSTF_FRAME_BITS) || slot_start;
            // Preamble opens with a one; the shifter loads on this same edge
            line_out <= slot_start ? 1'b1 :
                        (count_r[0] ? ~shift_r[233] : shift_r[233]);
        end
    end

    // Register read, one cycle after strobe
    always @(posedge clk_sys or negedge nrst) begin
        if (!nrst)
            reg_rdata <= 32'h00000000;
        else if (reg_rd) begin
            case (reg_addr)
            `TSTF_REG_CTRL:   reg_rdata <= {23'h0, ntp_susp_r, 5'h0,
                                            req_mode_r};
            `TSTF_REG_SETSEC: reg_rdata <= set_sec_r;
            `TSTF_REG_SCHED:  reg_rdata <= sched_r;
            `TSTF_REG_STATUS: reg_rdata <= {24'h0, ntp_susp_r, refused_r,
                                            tod_valid_r, warm_s, realign_r,
                                            mode_r};
            `TSTF_REG_COUNT:  reg_rdata <= count_r;
            `TSTF_REG_GPSSEC: reg_rdata <= gps_sec_r;
            `TSTF_REG_STEER:  reg_rdata <= {16'h0, steer_r};
            `TSTF_REG_NTPVER: reg_rdata <= {29'h0, ntp_ver_r};
            default:          reg_rdata <= 32'h00000000;
            endcase
        end else
            reg_rdata <= 32'h00000000;
    end
endmodule
`default_nettype wire

// >>> testbench/tstf_top_sva.sv
`timescale 1ns/100ps
`default_nettype none
module tstf_chk (
    input wire logic        clk_sys,
    input wire logic        nrst,
    input wire logic [3:0]  reg_addr,
    input wire logic [31:0] reg_wdata,
    input wire logic        reg_wr,
    input wire logic        gps_pps,
    input wire logic        line_out,
    input wire logic        line_oe,
    input wire logic        frame_clk,
    input wire logic [31:0] master_time_count
);
    logic        gps_r, ph_r, cln_r, fc_r;
    logic [2:0]  qt_r;
    logic [9:0]  oe_r, hi_r;
    logic [10:0] per_r;
    logic [31:0] exp_r;
    wire         ld = reg_wr && reg_addr == 4'h1;
    // Loads and GPS realignment may step the count, so those spans are skipped
    always @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            gps_r <= 1'b0;
            qt_r  <= 3'h0;
            cln_r <= 1'b0;
        end else begin
            if (reg_wr && reg_addr == 4'h0)
                gps_r <= reg_wdata[2:0] == 3'h4;
            qt_r <= (ld || gps_pps) ? 3'h0 : qt_r + {2'h0, qt_r != 3'h7};
            if (frame_clk && !fc_r)
                cln_r <= qt_r == 3'h7 && !gps_r;
            else if (qt_r != 3'h7 || gps_r)
                cln_r <= 1'b0;
        end
    end
    always @(posedge clk_sys) begin
        if (ld)
            exp_r <= {14'h0, reg_wdata[17:0]} * 32'h009C4000;
        fc_r  <= frame_clk;
        ph_r  <= line_oe & ~ph_r;
        oe_r  <= line_oe ? oe_r + 10'h1 : 10'h0;
        hi_r  <= frame_clk ? hi_r + 10'h1 : 10'h0;
        per_r <= (frame_clk && !fc_r) ? 11'h1 : per_r + 11'h1;
    end
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!nrst);
    chk_count_step: assert property (
        qt_r == 3'h7 && !gps_r |->
        master_time_count == $past(master_time_count) + 32'h1)
        else $error("count step");
    chk_map_load: assert property (
        ld |=> ##[0:1] master_time_count == exp_r) else $error("map load");
    chk_frame_rise: assert property (
        $rose(frame_clk) |-> $rose(line_oe)) else $error("frame edge");
    chk_frame_len: assert property (
        $fell(line_oe) && cln_r |-> oe_r == 10'h1D4) else $error("frame len");
    chk_manchester: assert property (
        line_oe && ph_r && cln_r |-> line_out != $past(line_out))
        else $error("code");
    chk_slot_period: assert property (
        $rose(frame_clk) && cln_r |-> per_r == 11'h400) else $error("slot");
    chk_half_slot: assert property (
        $fell(frame_clk) && cln_r |-> hi_r == 10'h200) else $error("half");
    chk_slot_phase: assert property (
        $rose(frame_clk) |-> master_time_count[9:0] < 10'h004)
        else $error("frame phase");
    cover property ($rose(frame_clk));
    cover property (ld);
    cover property ($fell(line_oe) && cln_r);
endmodule
bind tstf_top tstf_chk u_chk (.clk_sys, .nrst, .reg_addr, .reg_wdata,
    .reg_wr, .gps_pps, .line_out, .line_oe, .frame_clk, .master_time_count);
`default_nettype wire

// >>> testbench/tstf_client.sv
`timescale 1ns/100ps
`default_nettype none
module tstf_client (
    input  wire logic    clk_sys,
    input  wire logic    line_out,
    input  wire logic    line_oe,
    output logic [233:0] frm_r,
    output logic [8:0]   nbits_r,
    output logic         crc_ok_r,
    output logic         man_err_r,
    output logic         done_r
);
    logic        ph_r, oe_r, h1_r;
    logic [15:0] crc_r;
    // A bad frame only leaves the good flag low; recovery rides through it
    always @(posedge clk_sys) begin
        oe_r     <= line_oe;
        ph_r     <= line_oe & ~ph_r;
        done_r   <= oe_r & ~line_oe;
        crc_ok_r <= crc_r == frm_r[15:0];
        if (line_oe && !oe_r) begin
            nbits_r   <= 9'h000;
            man_err_r <= 1'b0;
            crc_r     <= 16'hFFFF;
        end
        if (line_oe && !ph_r)
            h1_r <= line_out;
        if (line_oe && ph_r) begin
            man_err_r <= man_err_r | (line_out == h1_r);
            frm_r     <= {frm_r[232:0], h1_r};
            nbits_r   <= nbits_r + 9'h001;
            if (nbits_r >= 9'h044 && nbits_r < 9'h0DA)
                crc_r <= {crc_r[14:0], 1'b0} ^
                         ({16{crc_r[15] ^ h1_r}} & 16'h1021);
        end
    end
endmodule
`default_nettype wire

// >>> testbench/tb.sv
`timescale 1ns/100ps
`default_nettype none
module tb;
    localparam [31:0] TPS = 32'h00000800;
    logic         clk_sys, nrst, reg_wr, reg_rd, gps_pps, warmup_done;
    logic         line_out, line_oe, frame_clk, freq_up, freq_dn;
    logic         crc_ok, man_err, done;
    logic [3:0]   reg_addr;
    logic [8:0]   nbits;
    logic [31:0]  reg_wdata, reg_rdata, master_time_count, rd, v, ts_r;
    logic [233:0] frm;
    int           num_errors, n_tests, cyc, k;
    tstf_top #(.TICKS_PER_SEC(TPS)) dut (.clk_sys, .nrst, .reg_addr,
        .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .gps_pps, .warmup_done,
        .line_out, .line_oe, .frame_clk, .freq_up, .freq_dn,
        .master_time_count);
    tstf_client u_cli (.clk_sys, .line_out, .line_oe, .frm_r(frm),
        .nbits_r(nbits), .crc_ok_r(crc_ok), .man_err_r(man_err), .done_r(done));
    initial begin
        clk_sys = 1'b0;
        forever #25 clk_sys = ~clk_sys;
    end
    always @(posedge frame_clk)
        ts_r <= master_time_count;
    always @(posedge clk_sys) begin
        cyc <= cyc + 1;
        if (cyc == 30000) begin
            num_errors++;
            close_out;
        end
    end
    task automatic chk(input logic [67:0] got, exp);
        n_tests++;
        if (got !== exp) begin
            num_errors++;
            $display("BAD %0t mismatch got %h exp %h", $time, got, exp);
        end
    endtask
    task automatic wr(input logic [3:0] a, input logic [31:0] d);
        reg_addr  <= a;
        reg_wdata <= d;
        reg_wr    <= 1'b1;
        @(posedge clk_sys);
        reg_wr <= 1'b0;
        @(posedge clk_sys);
    endtask
    task automatic rdr(input logic [3:0] a);
        reg_addr <= a;
        reg_rd   <= 1'b1;
        @(posedge clk_sys);
        reg_rd <= 1'b0;
        @(negedge clk_sys);
        rd = reg_rdata;
        @(posedge clk_sys);
    endtask
    task automatic rc(input logic [3:0] a, input logic [31:0] m, e);
        rdr(a);
        chk(rd & m, e);
    endtask
    function automatic logic [31:0] mapf(input logic [31:0] s);
        return {14'h0, s[17:0]} * 32'h009C4000;
    endfunction
    task automatic close_out;
        $display("tests %0d errors %0d", n_tests, num_errors);
        if (num_errors == 0 && n_tests > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask
    initial begin
        {nrst, reg_wr, reg_rd, gps_pps, warmup_done} = 5'h00;
        reg_addr  = 4'h0;
        reg_wdata = 32'h0;
        {num_errors, n_tests, cyc} = 0;
        repeat (6) @(posedge clk_sys);
        nrst <= 1'b1;
        @(posedge clk_sys);
        rc(4'h3, 32'h7, 32'h1);
        rc(4'h2, 32'hFFFFFFFF, 32'hFFFFFFFF);
        rc(4'h8, 32'h7, 32'h3);
        rc(4'hF, 32'hFFFFFFFF, 32'h0);
        for (k = 0; k < 4000 && done !== 1'b1; k++)
            @(posedge clk_sys);
        repeat (2) @(posedge clk_sys);
        for (k = 0; k < 2200 && done !== 1'b1; k++)
            @(negedge clk_sys);
        chk({crc_ok, man_err, nbits}, {2'h2, 9'h0EA});
        chk(frm[233:166], 68'hAAAAAAAAAAAAAAAA9);
        chk(frm[149:128], ts_r[31:10]);
        @(posedge clk_sys);
        $display("test reset and frame done");
        for (k = 0; k < 3; k++) begin
            v = k == 0 ? 32'h1 : k == 1 ? 32'h00040005 : 32'hFFFFFFFF;
            wr(4'h1, v);
            rc(4'h5, 32'hFFFFFFFF, v);
            rdr(4'h4);
            chk(rd - mapf(v) < 32'h8, 1'b1);
        end
        wr(4'h1, 32'h10);
        repeat (TPS) @(posedge clk_sys);
        rc(4'h5, 32'hFFFFFFFF, 32'h11);
        $display("test map done");
        for (k = 0; k < 3; k++) begin
            wr(4'h0, k);
            rc(4'h3, 32'h7, k);
        end
        wr(4'h0, 32'h0);
        wr(4'h8, 32'h2);
        wr(4'h0, 32'h2);
        rc(4'h3, 32'h47, 32'h40);
        wr(4'h8, 32'h3);
        warmup_done <= 1'b1;
        repeat (4) @(posedge clk_sys);
        wr(4'h0, 32'h202);
        rc(4'h3, 32'h47, 32'h40);
        wr(4'h0, 32'h102);
        rc(4'h3, 32'h87, 32'h82);
        $display("test mode done");
        rdr(4'h3);
        v = rd & 32'h20;
        wr(4'h2, 32'h100);
        wr(4'h0, 32'h4);
        rc(4'h3, 32'h27, v | 32'h3);
        wr(4'h6, 32'h7FFF);
        for (k = 0; k < 300 && freq_up !== 1'b1; k++)
            @(posedge clk_sys);
        chk({freq_up, freq_dn}, 2'h2);
        wr(4'h6, 32'h8001);
        @(posedge clk_sys);
        chk(freq_dn, 1'b1);
        rdr(4'h5);
        wr(4'h2, rd + 32'h1);
        repeat (2 * TPS) @(posedge clk_sys);
        rc(4'h3, 32'h7, 32'h4);
        gps_pps <= 1'b1;
        repeat (4) @(posedge clk_sys);
        gps_pps <= 1'b0;
        repeat (TPS) @(posedge clk_sys);
        rdr(4'h5);
        v = rd;
        rdr(4'h4);
        chk(rd - mapf(v) < 32'h1000 || rd - mapf(v - 1) < 32'h1000, 1'b1);
        $display("test gps done");
        close_out;
    end
endmodule
`default_nettype wire
